// >>> wiper_pkg.sv
// Constants and types shared by the two-wire wiper block and its fuse store.
// Assumes a 20 MHz system clock; the bus clock comes from the bus master.
package wiper_pkg;

  localparam int          CLK_HZ           = 20_000_000;
  localparam int          STORE_TIME_MS    = 350;
  localparam int          STORE_CYCLES_DEF = STORE_TIME_MS * (CLK_HZ / 1000);

  localparam int          WIPER_W          = 10;
  localparam int          WORD_W           = 16;
  localparam int          FUSE_AW          = 6;
  localparam int          FUSE_SLOTS_DEF   = 50;
  localparam int          CMD_LSB          = 10;
  localparam int          CMD_MSB          = 13;

  localparam logic [9:0]  WIPER_MID        = 10'h200;
  localparam logic [9:0]  WIPER_RST        = 10'h200;
  localparam logic [5:0]  FUSE_NONE        = 6'h00;
  localparam logic [5:0]  FUSE_FIRST       = 6'h01;
  localparam logic [15:0] READBACK_RST     = 16'h0000;

  localparam logic [4:0]  ADDR_UPPER       = 5'h0B;
  localparam logic [1:0]  ADDR_LEVEL_GND   = 2'h0;
  localparam logic [1:0]  ADDR_LEVEL_VDD   = 2'h1;
  localparam logic [1:0]  ADDR_LOW_GND     = 2'h3;
  localparam logic [1:0]  ADDR_LOW_VDD     = 2'h0;
  localparam logic [1:0]  ADDR_LOW_OPEN    = 2'h2;

  localparam logic [3:0]  CMD_WRITE        = 4'h1;
  localparam logic [3:0]  CMD_READ         = 4'h2;
  localparam logic [3:0]  CMD_STORE        = 4'h3;
  localparam logic [3:0]  CMD_RESTORE      = 4'h4;
  localparam logic [3:0]  CMD_READ_FUSE    = 4'h5;
  localparam logic [3:0]  CMD_READ_LAST    = 4'h6;

  localparam logic [3:0]  BIT_LAST         = 4'h7;
  localparam logic [3:0]  BIT_ACK          = 4'h8;
  localparam logic [3:0]  BIT_FIRST        = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
  } link_state_t;

endpackage

// >>> fuse_wiper_store.sv
// One-time store of wiper positions, one word per location.
// Assumes the caller never writes a location twice; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module fuse_wiper_store #(
  parameter int AW = 6,
  parameter int DW = 10
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= cells[raddr];
  end

endmodule
`default_nettype wire

// >>> wiper_i2c_slave.sv
// Two-wire slave holding the wiper position, with fuse store and restore.
// Assumes SCL is driven by the master, SDA is resolved outside from SDA_OE,
// and FUSE_BLANK is pulsed once for a factory-fresh part.
`timescale 1ns/1ps
`default_nettype none
module wiper_i2c_slave
  import wiper_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_CYCLES_DEF,
  parameter int FUSE_SLOTS   = FUSE_SLOTS_DEF
) (
  input  wire logic               CLK,
  input  wire logic               SRST,
  input  wire logic               SCL,
  input  wire logic               SDA_IN,
  output var  logic               SDA_OUT,
  output var  logic               SDA_OE,
  input  wire logic               RESET_N,
  input  wire logic [1:0]         ADDR_LEVEL,
  input  wire logic               FUSE_BLANK,
  output var  logic [WIPER_W-1:0] WIPER,
  output var  logic               BUSY
);

  localparam int               BW             = $clog2(STORE_CYCLES + 1);
  localparam logic [BW-1:0]    STORE_CYCLES_W = BW'(STORE_CYCLES);
  localparam logic [BW-1:0]    BUSY_LAST      = BW'(1);
  localparam logic [5:0]       FUSE_FULL      = 6'(FUSE_SLOTS);

  // ----------------------------------------------------------------
  // System-clock side: synchronisers, stop detect, link reset
  // ----------------------------------------------------------------
  logic [1:0]         scl_sy;
  logic [1:0]         sda_sy;
  logic [1:0]         rstn_sy;
  logic [1:0]         wtg_sy;
  logic [1:0]         lvl_meta;
  logic [1:0]         lvl_sy;
  logic               sda_d;
  logic               wtg_d;
  logic               link_rst;
  logic [1:0]         addr_lo;
  logic               word_tgl;
  logic [WORD_W-1:0]  word;
  logic               word_ev;
  logic [3:0]         cmd;

  always_ff @(posedge CLK) begin
    scl_sy  <= {scl_sy[0], SCL};
    sda_sy  <= {sda_sy[0], SDA_IN};
    rstn_sy <= {rstn_sy[0], RESET_N};
    wtg_sy  <= {wtg_sy[0], word_tgl};
    wtg_d   <= wtg_sy[1];
    sda_d   <= sda_sy[1];
    lvl_meta <= ADDR_LEVEL;
    lvl_sy   <= lvl_meta;
  end

  // A stop leaves SCL standing high, so the link side never sees it;
  // it is ended from here by a one-cycle reset of the link logic.
  always_ff @(posedge CLK) begin
    link_rst <= SRST | (scl_sy[1] & sda_sy[1] & ~sda_d);
  end

  assign word_ev = wtg_sy[1] ^ wtg_d;
  assign cmd     = word[CMD_MSB:CMD_LSB];

  // Strap caught while reset is held
  always_ff @(posedge CLK) begin
    if (SRST) begin
      unique case (lvl_sy)
        ADDR_LEVEL_GND: addr_lo <= ADDR_LOW_GND;
        ADDR_LEVEL_VDD: addr_lo <= ADDR_LOW_VDD;
        default:        addr_lo <= ADDR_LOW_OPEN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command execution, store, restore
  // ----------------------------------------------------------------
  logic [BW-1:0]      busy_cnt;
  logic [5:0]         fuse_last;
  logic [5:0]         raddr;
  logic [WIPER_W-1:0] mem_q;
  logic               store_go;
  logic               rest_req;
  logic               rest_pend;
  logic [1:0]         rest_p;
  logic [1:0]         fuse_p;
  logic               rest_ld;
  logic [WORD_W-1:0]  rdbk;

  assign store_go = word_ev & (cmd == CMD_STORE) & ~BUSY & (fuse_last != FUSE_FULL);
  assign rest_req = ~rstn_sy[1] | rest_pend | (word_ev & (cmd == CMD_RESTORE) & ~BUSY);
  assign rest_ld  = rest_p[1];

  always_ff @(posedge CLK) begin
    if (SRST) begin
      busy_cnt <= '0;
      BUSY     <= 1'b0;
    end else if (store_go) begin
      busy_cnt <= STORE_CYCLES_W;
      BUSY     <= 1'b1;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - BUSY_LAST;
      BUSY     <= (busy_cnt != BUSY_LAST);
    end
  end

  // Not cleared by SRST: the store outlives power cycles.
  always_ff @(posedge CLK) begin
    if (FUSE_BLANK) begin
      fuse_last <= FUSE_NONE;
    end else if (store_go) begin
      fuse_last <= fuse_last + FUSE_FIRST;
    end
  end

  fuse_wiper_store #(.AW(FUSE_AW), .DW(WIPER_W)) u_store (
    .clk   (CLK),
    .we    (store_go),
    .waddr (fuse_last + FUSE_FIRST),
    .wdata (WIPER),
    .raddr (raddr),
    .rdata (mem_q)
  );

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rest_pend <= 1'b1;
      rest_p    <= 2'b00;
      fuse_p    <= 2'b00;
      raddr     <= FUSE_NONE;
    end else begin
      rest_pend <= 1'b0;
      rest_p    <= {rest_p[0], rest_req};
      fuse_p    <= {fuse_p[0], word_ev & (cmd == CMD_READ_FUSE) & ~rest_req};
      if (rest_req) begin
        raddr <= fuse_last;
      end else if (word_ev & (cmd == CMD_READ_FUSE)) begin
        raddr <= word[5:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      WIPER <= WIPER_RST;
    end else if (rest_ld) begin
      WIPER <= (fuse_last == FUSE_NONE) ? WIPER_MID : mem_q;
    end else if (word_ev & (cmd == CMD_WRITE) & ~BUSY) begin
      WIPER <= word[WIPER_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdbk <= READBACK_RST;
    end else if (fuse_p[1]) begin
      rdbk <= {6'h00, mem_q};
    end else if (word_ev & (cmd == CMD_READ)) begin
      rdbk <= {6'h00, WIPER};
    end else if (word_ev & (cmd == CMD_READ_LAST)) begin
      rdbk <= {10'h000, fuse_last};
    end
  end

  always_ff @(posedge CLK) begin
    SDA_OUT <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Link side, clocked by SCL
  // ----------------------------------------------------------------
  logic        pos_sda;
  logic [1:0]  busy_sy;
  logic        start;
  logic [7:0]  sh;
  logic [7:0]  hi;
  logic [3:0]  cnt;
  logic        rw;
  logic        byte_sel;
  logic [7:0]  tx_byte;
  link_state_t state;

  always_ff @(posedge SCL or posedge link_rst) begin
    if (link_rst) begin
      pos_sda <= 1'b1;
      busy_sy <= 2'b00;
    end else begin
      pos_sda <= SDA_IN;
      busy_sy <= {busy_sy[0], BUSY};
    end
  end

  // SDA fell while SCL was high: a start or repeated start
  assign start   = pos_sda & ~SDA_IN;
  assign tx_byte = byte_sel ? rdbk[7:0] : rdbk[15:8];

  // Everything moves on the falling edge so SDA changes only while SCL is low.
  always_ff @(negedge SCL or posedge link_rst) begin
    if (link_rst) begin
      state    <= ST_IDLE;
      SDA_OE   <= 1'b0;
      sh       <= 8'h00;
      hi       <= 8'h00;
      cnt      <= 4'h0;
      rw       <= 1'b0;
      byte_sel <= 1'b0;
      word     <= 16'h0000;
      word_tgl <= 1'b0;
    end else if (start) begin
      state  <= ST_ADDR;
      SDA_OE <= 1'b0;
      cnt    <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          SDA_OE <= 1'b0;
        end
        ST_ADDR: begin
          sh  <= {sh[6:0], pos_sda};
          cnt <= cnt + BIT_FIRST;
          if (cnt == BIT_LAST) begin
            if (sh[6:0] == {ADDR_UPPER, addr_lo} && !busy_sy[1]) begin
              SDA_OE <= 1'b1;
              rw     <= pos_sda;
              state  <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          byte_sel <= 1'b0;
          if (rw) begin
            SDA_OE <= ~rdbk[15];
            cnt    <= BIT_FIRST;
            state  <= ST_READ;
          end else begin
            SDA_OE <= 1'b0;
            cnt    <= 4'h0;
            state  <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          sh  <= {sh[6:0], pos_sda};
          cnt <= cnt + BIT_FIRST;
          if (cnt == BIT_LAST) begin
            if (busy_sy[1]) begin
              state <= ST_IDLE;
            end else begin
              SDA_OE <= 1'b1;
              state  <= ST_WRITE_ACK;
              if (byte_sel) begin
                word     <= {hi, sh[6:0], pos_sda};
                word_tgl <= ~word_tgl;
              end else begin
                hi <= {sh[6:0], pos_sda};
              end
            end
          end
        end
        ST_WRITE_ACK: begin
          SDA_OE   <= 1'b0;
          cnt      <= 4'h0;
          byte_sel <= ~byte_sel;
          state    <= ST_WRITE;
        end
        ST_READ: begin
          if (cnt == BIT_ACK) begin
            SDA_OE <= 1'b0;
            state  <= ST_READ_ACK;
          end else begin
            SDA_OE <= ~tx_byte[3'h7 - cnt[2:0]];
            cnt    <= cnt + BIT_FIRST;
          end
        end
        ST_READ_ACK: begin
          if (!pos_sda && !byte_sel) begin
            byte_sel <= 1'b1;
            SDA_OE   <= ~rdbk[7];
            cnt      <= BIT_FIRST;
            state    <= ST_READ;
          end else begin
            SDA_OE <= 1'b0;
            state  <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_restore_pipe;
    rest_p[0] ##1 rest_ld;
  endsequence

  property p_hw_restore;
    !rstn_sy[1] |-> ##1 s_restore_pipe;
  endproperty
  a_hw_restore: assert property (p_hw_restore) else $error("restore not started by reset pin");

  property p_mid;
    rest_ld && fuse_last == FUSE_NONE |=> WIPER == WIPER_MID;
  endproperty
  a_mid: assert property (p_mid) else $error("blank restore did not give midscale");

  property p_stored;
    rest_ld && fuse_last != FUSE_NONE |=> WIPER == $past(mem_q);
  endproperty
  a_stored: assert property (p_stored) else $error("restore did not load stored value");

  property p_write;
    word_ev && cmd == CMD_WRITE && !BUSY && !rest_ld |=> WIPER == $past(word[WIPER_W-1:0]);
  endproperty
  a_write: assert property (p_write) else $error("wiper write lost");

  property p_store_ptr;
    store_go |=> fuse_last == $past(fuse_last) + FUSE_FIRST && BUSY && busy_cnt == STORE_CYCLES_W;
  endproperty
  a_store_ptr: assert property (p_store_ptr) else $error("store pointer or busy wrong");

  property p_busy_end;
    BUSY && busy_cnt == BUSY_LAST |=> !BUSY ##1 !BUSY;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy interval length wrong");

  property p_no_ack_busy;
    @(negedge SCL) disable iff (link_rst)
    state == ST_ADDR && cnt == BIT_LAST && busy_sy[1] && !start |=> state == ST_IDLE && !SDA_OE;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) else $error("acknowledged while busy");

  property p_addr_ack;
    @(negedge SCL) disable iff (link_rst)
    state == ST_ADDR && cnt == BIT_LAST && !busy_sy[1] && !start && sh[6:0] == {ADDR_UPPER, addr_lo}
      |=> SDA_OE && state == ST_ADDR_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

  property p_nack;
    @(negedge SCL) disable iff (link_rst)
    state == ST_READ_ACK && pos_sda && !byte_sel && !start |=> !SDA_OE && state == ST_IDLE;
  endproperty
  a_nack: assert property (p_nack) else $error("second byte sent after nack");

endmodule
`default_nettype wire

// >>> i2c_master_model.sv
// Bus master model for the wiper block's two-wire link.
// Assumes the bench resolves SDA from all pull-downs with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  output var  logic scl,
  output var  logic sda_pull,
  input  wire logic sda
);
  // --------------------------------
  // Bit timing of a 125 ns link clock
  // --------------------------------
  localparam realtime Q = 31.25;
  localparam realtime H = 5.0;
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  // SCL stands still high between frames
  task automatic start();
    sda_pull = 1'h1;
    #(2 * Q);
    scl = 1'h0;
    #H;
  endtask
  // SDA moves just after SCL falls: the slave's stop detector samples both lines
  // on the system clock, so a change late in the low phase could meet SCL high
  task automatic bit_io(input logic b, output logic s);
    sda_pull = ~b;
    #(2 * Q - H);
    scl = 1'h1;
    #Q;
    s = sda;
    #Q;
    scl = 1'h0;
    #H;
  endtask
  task automatic stop();
    sda_pull = 1'h1;
    #(2 * Q - H);
    scl = 1'h1;
    #Q;
    sda_pull = 1'h0;
    #300;  // Bus stays free long enough for the slave's stop sync
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'h1, s);
    ack = ~s;
  endtask
  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, d[i]);
    end
    bit_io(~ack, s);
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the two-wire wiper block and its fuse store.
// Assumes i2c_master_model as bus master and a shortened store interval.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wiper_pkg::*;
;
  localparam int STORE_N = 80;
  logic       clk        = 1'h0;
  logic       srst       = 1'h1;
  logic       reset_n    = 1'h1;
  logic [1:0] addr_level = ADDR_LEVEL_GND;
  logic       fuse_blank = 1'h1;
  logic       scl;
  logic       m_pull;
  logic       sda_out;
  logic       sda_oe;
  logic [9:0] wiper;
  logic       busy;
  wire logic  sda;
  logic [1:0] lo         = 2'h3;
  logic [9:0] vals [3]   = '{10'h3FF, 10'h2AB, 10'h0F0};
  int         busy_n     = 0;
  int         err_total  = 0;
  int         n_compared = 0;
  // --------------------------------
  // Clocks, wire and instances
  // --------------------------------
  always #25 clk = ~clk;
  always @(posedge clk) busy_n <= busy ? busy_n + 1 : busy_n;
  assign sda = ~((sda_oe & ~sda_out) | m_pull);
  wiper_i2c_slave #(.STORE_CYCLES(STORE_N), .FUSE_SLOTS(FUSE_SLOTS_DEF)) dut (
    .CLK(clk), .SRST(srst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .RESET_N(reset_n), .ADDR_LEVEL(addr_level), .FUSE_BLANK(fuse_blank), .WIPER(wiper), .BUSY(busy));
  i2c_master_model host (.scl(scl), .sda_pull(m_pull), .sda(sda));
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cb(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask
  // Power cycle; the blank-part flag is dropped after the first one
  task automatic por(input logic [1:0] lvl);
    @(negedge clk);
    srst = 1'h1;
    addr_level = lvl;
    repeat (16) @(negedge clk);
    srst = 1'h0;
    fuse_blank = 1'h0;
    repeat (8) @(negedge clk);
  endtask
  task automatic pin_reset();
    @(negedge clk);
    reset_n = 1'h0;
    repeat (3) @(negedge clk);
    reset_n = 1'h1;
    repeat (6) @(negedge clk);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [9:0] d, output logic ak);
    logic a0, a1, a2;
    host.start();
    host.wr({ADDR_UPPER, lo, 1'h0}, a0);
    host.wr({2'h0, c, d[9:8]}, a1);
    host.wr(d[7:0], a2);
    host.stop();
    ak = a0 & a1 & a2;
    repeat (4) @(negedge clk);
  endtask
  task automatic rdw(output logic [15:0] v);
    logic a;
    host.start();
    host.wr({ADDR_UPPER, lo, 1'h1}, a);
    host.rd(1'h1, v[15:8]);
    host.rd(1'h0, v[7:0]);
    host.stop();
    cb(a, 1'h1);
    cb(sda_out, 1'h0);
  endtask
  task automatic poll();
    logic a;
    for (int i = 0; i < 20; i++) begin
      host.start();
      host.wr({ADDR_UPPER, lo, 1'h0}, a);
      host.stop();
      if (a === 1'h1) return;
    end
    err_total++;
    close_out();
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_addr();
    logic [1:0] lv [3] = '{ADDR_LEVEL_VDD, 2'h2, ADDR_LEVEL_GND};
    logic [1:0] lb [3] = '{2'h0, 2'h2, 2'h3};
    logic       a;
    for (int j = 0; j < 3; j++) begin
      por(lv[j]);
      cmp({6'h00, wiper}, 16'h0200);
      for (int k = 0; k < 4; k++) begin
        host.start();
        host.wr({5'h0B, 2'(k), 1'h0}, a);
        host.stop();
        cb(a, 2'(k) == lb[j]);
      end
    end
  endtask
  task automatic t_write();
    logic [15:0] v;
    logic        ak;
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_WRITE, vals[2 - i], ak);
      cb(ak, 1'h1);
      cmp({6'h00, wiper}, {6'h00, vals[2 - i]});
    end
    cmd(CMD_READ, 10'h000, ak);
    rdw(v);
    cmp({6'h00, v[9:0]}, {6'h00, vals[0]});
    pin_reset();
    cmp({6'h00, wiper}, 16'h0200);
  endtask
  // After a nack the extra byte clocked must stay released
  task automatic t_nack();
    logic [7:0] b0, b1;
    logic       a;
    host.start();
    host.wr({ADDR_UPPER, lo, 1'h1}, a);
    host.rd(1'h0, b0);
    host.rd(1'h0, b1);
    host.stop();
    cb(a, 1'h1);
    cmp({8'h00, b0}, {14'h0000, vals[0][9:8]});
    cmp({8'h00, b1}, 16'h00FF);
  endtask
  task automatic t_store();
    logic [15:0] v;
    logic        ak;
    int          busy0;
    for (int i = 1; i <= 2; i++) begin
      cmd(CMD_WRITE, vals[i], ak);
      busy0 = busy_n;
      cmd(CMD_STORE, 10'h000, ak);
      cb(busy, 1'h1);
      cmd(CMD_WRITE, 10'h111, ak);
      cb(ak, 1'h0);
      poll();
      cmp({6'h00, wiper}, {6'h00, vals[i]});
      cmp(16'(busy_n - busy0), 16'(STORE_N));
      cmd(CMD_READ_LAST, 10'h000, ak);
      rdw(v);
      cmp({10'h000, v[5:0]}, 16'(i));
    end
    cmd(CMD_READ_FUSE, 10'h001, ak);
    rdw(v);
    cmp({6'h00, v[9:0]}, {6'h00, vals[1]});
  endtask
  task automatic t_restore();
    logic ak;
    cmd(CMD_WRITE, 10'h001, ak);
    pin_reset();
    cmp({6'h00, wiper}, {6'h00, vals[2]});
    cmd(CMD_WRITE, 10'h001, ak);
    cmd(CMD_RESTORE, 10'h000, ak);
    cmp({6'h00, wiper}, {6'h00, vals[2]});
    cmd(CMD_WRITE, 10'h001, ak);
    por(ADDR_LEVEL_GND);
    cmp({6'h00, wiper}, {6'h00, vals[2]});
  endtask
  initial begin
    t_addr();
    t_write();
    t_nack();
    t_store();
    t_restore();
    close_out();
  end
endmodule
`default_nettype wire
